// file: athys_consts.vh
// Constants for the acquisition trigger hysteresis block
`ifndef ATHYS_CONSTS_VH
`define ATHYS_CONSTS_VH
// =====================================================
// Register byte offsets
`define ATHYS_OFS_CTRL 8'h00
`define ATHYS_OFS_COUNT 8'h04
`define ATHYS_OFS_CURR_LEVEL 8'h08
`define ATHYS_OFS_CURR_BAND 8'h0C
`define ATHYS_OFS_METER_LEVEL 8'h10
`define ATHYS_OFS_METER_BAND 8'h14
`define ATHYS_OFS_VOLT_LEVEL 8'h18
`define ATHYS_OFS_VOLT_BAND 8'h1C
`define ATHYS_OFS_STATUS 8'h20
// =====================================================
// Control field positions
`define ATHYS_CTRL_ARM 0
`define ATHYS_CTRL_ABORT 1
`define ATHYS_CTRL_SRC_LO 2
`define ATHYS_CTRL_SLOPE_LO 4
// =====================================================
// Source and slope codes
`define ATHYS_SRC_VOLT 2'h0
`define ATHYS_SRC_CURR 2'h1
`define ATHYS_SRC_METER 2'h2
`define ATHYS_SLOPE_RISE 2'h0
`define ATHYS_SLOPE_FALL 2'h1
`define ATHYS_SLOPE_EITHER 2'h2
// =====================================================
// Reset values and limits
`define ATHYS_COUNT_MIN 7'h01
`define ATHYS_COUNT_MAX 7'h64
`define ATHYS_COUNT_RST 7'h01
`define ATHYS_BAND_RST 16'h0000
`define ATHYS_LEVEL_RST 16'h0000
`endif

// file: athys_band_detect.v
// Hysteresis band crossing detector for one sampled quantity
`timescale 1ns/100ps
module athys_band_detect (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire sample_valid,
    input wire [15:0] sample,
    input wire [15:0] level,
    input wire [15:0] band,
    output reg rise_reg,
    output reg fall_reg
);
    // =====================================================
    // Band limits
    wire [16:0] half_band;
    wire [16:0] upper;
    wire [16:0] lower;
    wire below;
    wire above;
    // Zone memory: 0 none seen, 1 below band, 2 above band
    reg [1:0] zone_reg;
    reg [1:0] zone_next;

    assign half_band = {2'h0, band[15:1]};
    // Upper limit is level plus half the band
    assign upper = {1'h0, level} + half_band;
    // Lower limit saturates at zero, where an unsigned sample can never go under it
    assign lower = ({1'h0, level} > half_band) ? ({1'h0, level} - half_band) : 17'h00000;
    // With a zero band both limits equal the level itself
    assign below = ({1'h0, sample} < lower);
    assign above = ({1'h0, sample} > upper);

    // =====================================================
    // Zone tracking
    always @* begin
        zone_next = zone_reg;
        if (clear) begin
            zone_next = 2'h0;
        end else if (sample_valid && below) begin
            zone_next = 2'h1;
        end else if (sample_valid && above) begin
            zone_next = 2'h2;
        end
    end

    // Edges need a prior opposite zone, so in-band wobble never fires
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zone_reg <= 2'h0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            zone_reg <= zone_next;
            rise_reg <= !clear && sample_valid && above && (zone_reg == 2'h1);
            fall_reg <= !clear && sample_valid && below && (zone_reg == 2'h2);
        end
    end
endmodule // athys_band_detect

// file: athys_trigger.v
// Acquisition trigger qualifier with hysteresis, sample count and AHB-Lite registers
// Summary of operation
// - Sample count holds 1 to 100, resets to 1, sets measurements per acquisition.
// - After each measurement completes, wait for the next qualifying crossing.
// - Current band limits are level plus and minus half the band width.
// - Rising current trigger needs a sample below lower, then above upper.
// - Falling current trigger needs a sample above upper, then below lower.
// - Current band width settable from zero upward, resets to zero.
// - Meter input has its own band around its level, resetting to zero.
// - Rising meter trigger needs below lower first, then above upper.
// - Falling meter trigger needs above upper first, then below lower.
// - Slope is rising, falling or either; rising after reset.
// - Each qualifying trigger starts a measurement of the selected quantity.
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "athys_consts.vh"
module athys_trigger (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout_reg,
    output reg hresp_reg,
    output reg [31:0] hrdata_reg,
    input wire sample_valid,
    input wire [15:0] volt_sample,
    input wire [15:0] curr_sample,
    input wire [15:0] meter_sample,
    input wire meas_done,
    output reg meas_start_reg,
    output reg [1:0] meas_sel_reg,
    output reg acq_active_reg
);
    // =====================================================
    // States
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_MEAS = 2'h2;

    // =====================================================
    // Declarations
    reg [1:0] state_reg;
    reg [1:0] src_reg;
    reg [1:0] slope_reg;
    reg [6:0] count_reg;
    reg [6:0] taken_reg;
    reg done_reg;
    reg [15:0] curr_level_reg;
    reg [15:0] curr_band_reg;
    reg [15:0] meter_level_reg;
    reg [15:0] meter_band_reg;
    reg [15:0] volt_level_reg;
    reg [15:0] volt_band_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    wire addr_phase;
    wire [7:0] ap_addr;
    wire wr_now;
    wire arm_wr;
    wire abort_wr;
    wire [2:0] rise_v;
    wire [2:0] fall_v;
    reg sel_rise;
    reg sel_fall;
    wire qualified;

    // =====================================================
    // Helper functions
    // Slope filter shared by every source
    function slope_pass;
        input [1:0] slope;
        input r;
        input f;
        begin
            case (slope)
                `ATHYS_SLOPE_RISE: slope_pass = r;
                `ATHYS_SLOPE_FALL: slope_pass = f;
                `ATHYS_SLOPE_EITHER: slope_pass = r | f;
                default: slope_pass = 1'b0;
            endcase
        end
    endfunction

    // Register read mux, used for the read data register
    function [31:0] read_word;
        input [7:0] a;
        begin
            case (a)
                `ATHYS_OFS_CTRL: read_word = {26'h0000000, slope_reg, src_reg, 2'h0};
                `ATHYS_OFS_COUNT: read_word = {25'h0000000, count_reg};
                `ATHYS_OFS_CURR_LEVEL: read_word = {16'h0000, curr_level_reg};
                `ATHYS_OFS_CURR_BAND: read_word = {16'h0000, curr_band_reg};
                `ATHYS_OFS_METER_LEVEL: read_word = {16'h0000, meter_level_reg};
                `ATHYS_OFS_METER_BAND: read_word = {16'h0000, meter_band_reg};
                `ATHYS_OFS_VOLT_LEVEL: read_word = {16'h0000, volt_level_reg};
                `ATHYS_OFS_VOLT_BAND: read_word = {16'h0000, volt_band_reg};
                `ATHYS_OFS_STATUS: read_word = {15'h0000, done_reg, 1'h0, taken_reg, 6'h00, state_reg};
                default: read_word = 32'h00000000;
            endcase
        end
    endfunction

    // =====================================================
    // AHB-Lite slave, zero wait states
    assign addr_phase = hsel && htrans[1] && hready;
    assign ap_addr = {haddr[7:2], 2'h0};
    assign wr_now = wr_pend_reg;
    assign arm_wr = wr_now && (wr_addr_reg == `ATHYS_OFS_CTRL) && hwdata[`ATHYS_CTRL_ARM];
    assign abort_wr = wr_now && (wr_addr_reg == `ATHYS_OFS_CTRL) && hwdata[`ATHYS_CTRL_ABORT];

    // Address phase capture; read data is fetched early so the data phase needs no wait
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b0;
            hresp_reg <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= ap_addr;
            end
            if (addr_phase && !hwrite) begin
                hrdata_reg <= read_word(ap_addr);
            end
        end
    end

    // Settings registers; an out-of-range count is dropped so the old value stands
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_reg <= `ATHYS_SRC_VOLT;
            slope_reg <= `ATHYS_SLOPE_RISE;
            count_reg <= `ATHYS_COUNT_RST;
            curr_level_reg <= `ATHYS_LEVEL_RST;
            curr_band_reg <= `ATHYS_BAND_RST;
            meter_level_reg <= `ATHYS_LEVEL_RST;
            meter_band_reg <= `ATHYS_BAND_RST;
            volt_level_reg <= `ATHYS_LEVEL_RST;
            volt_band_reg <= `ATHYS_BAND_RST;
        end else if (wr_now) begin
            case (wr_addr_reg)
                `ATHYS_OFS_CTRL: begin
                    src_reg <= hwdata[`ATHYS_CTRL_SRC_LO+1:`ATHYS_CTRL_SRC_LO];
                    slope_reg <= hwdata[`ATHYS_CTRL_SLOPE_LO+1:`ATHYS_CTRL_SLOPE_LO];
                end
                `ATHYS_OFS_COUNT: begin
                    if (hwdata[31:7] == 25'h0000000 && hwdata[6:0] >= `ATHYS_COUNT_MIN
                        && hwdata[6:0] <= `ATHYS_COUNT_MAX) begin
                        count_reg <= hwdata[6:0];
                    end
                end
                `ATHYS_OFS_CURR_LEVEL: curr_level_reg <= hwdata[15:0];
                `ATHYS_OFS_CURR_BAND: curr_band_reg <= hwdata[15:0];
                `ATHYS_OFS_METER_LEVEL: meter_level_reg <= hwdata[15:0];
                `ATHYS_OFS_METER_BAND: meter_band_reg <= hwdata[15:0];
                `ATHYS_OFS_VOLT_LEVEL: volt_level_reg <= hwdata[15:0];
                `ATHYS_OFS_VOLT_BAND: volt_band_reg <= hwdata[15:0];
                default: src_reg <= src_reg;
            endcase
        end
    end

    // =====================================================
    // Crossing detectors, one per quantity; history is cleared on arming
    athys_band_detect u_volt (.hclk(hclk), .hresetn(hresetn), .clear(arm_wr), .sample_valid(sample_valid),
        .sample(volt_sample), .level(volt_level_reg), .band(volt_band_reg), .rise_reg(rise_v[0]),
        .fall_reg(fall_v[0]));
    athys_band_detect u_curr (.hclk(hclk), .hresetn(hresetn), .clear(arm_wr), .sample_valid(sample_valid),
        .sample(curr_sample), .level(curr_level_reg), .band(curr_band_reg), .rise_reg(rise_v[1]),
        .fall_reg(fall_v[1]));
    athys_band_detect u_meter (.hclk(hclk), .hresetn(hresetn), .clear(arm_wr), .sample_valid(sample_valid),
        .sample(meter_sample), .level(meter_level_reg), .band(meter_band_reg), .rise_reg(rise_v[2]),
        .fall_reg(fall_v[2]));

    // Pick the edges of the selected quantity
    always @* begin
        case (src_reg)
            `ATHYS_SRC_CURR: begin
                sel_rise = rise_v[1];
                sel_fall = fall_v[1];
            end
            `ATHYS_SRC_METER: begin
                sel_rise = rise_v[2];
                sel_fall = fall_v[2];
            end
            default: begin
                sel_rise = rise_v[0];
                sel_fall = fall_v[0];
            end
        endcase
    end

    assign qualified = slope_pass(slope_reg, sel_rise, sel_fall);

    // =====================================================
    // Acquisition sequencer
    // A crossing seen during a measurement is dropped: only one measurement runs at a time
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            taken_reg <= 7'h00;
            done_reg <= 1'b0;
            meas_start_reg <= 1'b0;
            meas_sel_reg <= `ATHYS_SRC_VOLT;
            acq_active_reg <= 1'b0;
        end else begin
            meas_start_reg <= 1'b0;
            if (abort_wr) begin
                state_reg <= ST_IDLE;
                acq_active_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        // One arm serves the whole count
                        if (arm_wr) begin
                            state_reg <= ST_WAIT;
                            taken_reg <= 7'h00;
                            done_reg <= 1'b0;
                            acq_active_reg <= 1'b1;
                        end
                    end
                    ST_WAIT: begin
                        if (qualified) begin
                            meas_start_reg <= 1'b1;
                            meas_sel_reg <= src_reg;
                            state_reg <= ST_MEAS;
                        end
                    end
                    ST_MEAS: begin
                        if (meas_done) begin
                            taken_reg <= taken_reg + 7'h01;
                            if (taken_reg + 7'h01 >= count_reg) begin
                                state_reg <= ST_IDLE;
                                done_reg <= 1'b1;
                                acq_active_reg <= 1'b0;
                            end else begin
                                state_reg <= ST_WAIT;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        acq_active_reg <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // athys_trigger

// file: athys_trigger_props.sv
// Property checker for the acquisition trigger hysteresis block
`timescale 1ns/100ps
module athys_trigger_props (
    input wire hclk,
    input wire hresetn,
    input wire hwrite,
    input wire sample_valid,
    input wire meas_done,
    input wire hreadyout_reg,
    input wire hresp_reg,
    input wire meas_start_reg,
    input wire [1:0] meas_sel_reg,
    input wire acq_active_reg
);
    // ==============================================
    // Clocking and named sequences: one-cycle start pulse, two idle cycles
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_one_shot;
        meas_start_reg ##1 !meas_start_reg;
    endsequence
    sequence s_idle_twice;
        !acq_active_reg ##1 !acq_active_reg;
    endsequence
    // ==============================================
    // Bus answers and trigger sequencing
    a_resp_okay: assert property (hresp_reg == 1'b0)
        else $error("slave response not OKAY");
    a_ready_high: assert property ($past(hresetn) |-> hreadyout_reg)
        else $error("wait state inserted");
    a_start_pulse: assert property (meas_start_reg |-> s_one_shot)
        else $error("start pulse longer than one cycle");
    a_start_active: assert property (meas_start_reg |-> acq_active_reg)
        else $error("start outside an acquisition");
    a_idle_quiet: assert property (s_idle_twice |-> !meas_start_reg)
        else $error("start while idle");
    a_sel_changes: assert property ($changed(meas_sel_reg) |-> meas_start_reg)
        else $error("selection moved without a start");
    a_start_sampled: assert property (meas_start_reg |-> $past(sample_valid, 2))
        else $error("start without a sample two cycles before");
    a_active_drop: assert property ($fell(acq_active_reg) |-> $past(meas_done) || $past(hwrite, 2))
        else $error("acquisition ended without cause");
endmodule // athys_trigger_props

bind athys_trigger athys_trigger_props u_props (
    .hclk(hclk),
    .hresetn(hresetn),
    .hwrite(hwrite),
    .sample_valid(sample_valid),
    .meas_done(meas_done),
    .hreadyout_reg(hreadyout_reg),
    .hresp_reg(hresp_reg),
    .meas_start_reg(meas_start_reg),
    .meas_sel_reg(meas_sel_reg),
    .acq_active_reg(acq_active_reg)
);

// file: tb.sv
// Self-checking testbench for the acquisition trigger hysteresis block
`timescale 1ns/100ps
`include "athys_consts.vh"
module tb;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg hwrite = 1'b0;
    reg sample_valid = 1'b0;
    reg meas_done = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] haddr = 32'h0;
    reg [31:0] hwdata = 32'h0;
    reg [15:0] smp = 16'h0;
    reg [31:0] seed = 32'h52ED6266;
    reg [31:0] rd, t;
    reg [31:0] n_start = 0;
    reg [31:0] cyc = 0;
    reg [15:0] lvl, bw, lo, hi;
    reg [7:0] la;
    integer failures = 0;
    integer n_checks = 0;
    integer taken, cnt, src, i, k;
    wire hreadyout_reg, hresp_reg, meas_start_reg, acq_active_reg;
    wire [31:0] hrdata_reg;
    wire [1:0] meas_sel_reg;

    athys_trigger dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_reg),
        .hreadyout_reg(hreadyout_reg), .hresp_reg(hresp_reg), .hrdata_reg(hrdata_reg),
        .sample_valid(sample_valid), .volt_sample(src == 0 ? smp : ~smp),
        .curr_sample(src == 1 ? smp : ~smp), .meter_sample(src == 2 ? smp : ~smp),
        .meas_done(meas_done), .meas_start_reg(meas_start_reg), .meas_sel_reg(meas_sel_reg),
        .acq_active_reg(acq_active_reg));

    // ==============================================
    // Clock, start counter and hang guard
    initial begin
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (meas_start_reg)
            n_start <= n_start + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            print_verdict;
        end
    end

    // ==============================================
    // Helpers
    function automatic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    // Status word after a finished acquisition of c measurements: idle, taken = c, done set
    function [31:0] exp_status(input integer c);
        exp_status = 32'h00010000 | (c << 8);
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One single transfer; the master waits on hready, never on a fixed count
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {24'h0, a};
            do @(posedge hclk); while (hreadyout_reg !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            do @(posedge hclk); while (hreadyout_reg !== 1'b1);
            rd = hrdata_reg;
        end
    endtask
    // One sample, then count starts; a fired start is finished by the measurement path
    task step(input [15:0] v, input want);
        reg [31:0] n0;
        begin
            n0 = n_start;
            smp <= v;
            sample_valid <= 1'b1;
            @(posedge hclk);
            sample_valid <= 1'b0;
            repeat (5) @(posedge hclk);
            want = want && (taken < cnt);
            chk(n_start - n0, {31'h0, want});
            if (want) begin
                chk({30'h0, meas_sel_reg}, src);
                taken = taken + 1;
                meas_done <= 1'b1;
                @(posedge hclk);
                meas_done <= 1'b0;
                @(posedge hclk);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks=%0d failures=%0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // ==============================================
    // Main sequence
    initial begin
        src = 0;
        taken = 0;
        cnt = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        // Reset values, status and one unmapped offset
        for (k = 0; k < 10; k = k + 1) begin
            bus(1'b0, k * 4, 32'h0);
            chk(rd, k == 1);
        end
        // Out-of-range counts must leave the boundary value in place
        bus(1'b1, `ATHYS_OFS_COUNT, 32'h64);
        bus(1'b1, `ATHYS_OFS_COUNT, 32'h0);
        bus(1'b1, `ATHYS_OFS_COUNT, 32'h65);
        bus(1'b0, `ATHYS_OFS_COUNT, 32'h0);
        chk(rd, 32'h64);
        // Each source with its own slope: volt rise, curr fall, meter either
        for (src = 0; src < 3; src = src + 1) begin
            t = rnd();
            lvl = 16'h1000 + {3'h0, t[12:0]};
            bw = (src == 0) ? 16'h0 : {3'h0, t[28:16]};
            lo = lvl - bw / 2;
            hi = lvl + bw / 2;
            cnt = (src == 0) ? 100 : 1 + t[30:29];
            taken = 0;
            la = 8'h08 * ((src + 2) % 3 + 1);
            bus(1'b1, la, {16'h0, lvl});
            bus(1'b1, la + 8'h04, {16'h0, bw});
            bus(1'b1, `ATHYS_OFS_COUNT, cnt);
            bus(1'b0, la + 8'h04, 32'h0);
            chk(rd, {16'h0, bw});
            bus(1'b1, `ATHYS_OFS_CTRL, (src << 4) | (src << 2) | 1);
            for (i = 0; i < cnt + 2; i = i + 1) begin
                step(lo - 16'h1, src != 0 && i > 0);
                step(hi, 1'b0);
                step(hi + 16'h1, src != 1);
            end
            chk(acq_active_reg, 1'b0);
            bus(1'b0, `ATHYS_OFS_STATUS, 32'h0);
            chk(rd, exp_status(cnt));
        end
        // Abort ends an armed acquisition at once
        bus(1'b1, `ATHYS_OFS_CTRL, 32'h1);
        @(posedge hclk);
        chk(acq_active_reg, 1'b1);
        bus(1'b1, `ATHYS_OFS_CTRL, 32'h2);
        @(posedge hclk);
        chk(acq_active_reg, 1'b0);
        print_verdict;
    end
endmodule // tb
